// >>> core/pcc_device.sv
/*
 Device end of the acyclic parameter channel: decodes each request,
 looks up a small parameter store and returns a response telegram.
 Assumes the master holds request words stable while req_valid is high
 and that only one request is outstanding.
*/
`timescale 1ns/100ps
module pcc_device
   import pcc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   pcc_link_if.device       link,
   input  wire logic [3:0]  process_word_count,
   output logic      [16:0] last_param_id,
   output logic             busy
);
   // -----------------------------------------------------------------
   // states and storage
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      PCC_ST_IDLE  = 3'b001,
      PCC_ST_EXEC  = 3'b010,
      PCC_ST_HOLD  = 3'b100
   } pcc_state_t;

   localparam int PCC_STORE_N = 4;
   pcc_state_t state;
   pcc_state_t next_state;
   pcc_word_t  store [PCC_STORE_N];
   pcc_word_t  rsp   [PCC_MAX_WORDS];
   logic       rsp_v;

   // -----------------------------------------------------------------
   // request field split
   // -----------------------------------------------------------------
   wire pcc_word_t  ident  = link.req_word[PCC_IDX_IDENT];
   wire pcc_word_t  index  = link.req_word[PCC_IDX_INDEX];
   wire pcc_word_t  value1 = link.req_word[PCC_IDX_VALUE1];
   wire pcc_word_t  value2 = link.req_word[PCC_IDX_VALUE2];
   wire [3:0]  req_code   = ident[15:PCC_RESP_LSB];
   wire [10:0] param_number = ident[PCC_PNUM_MSB:0];
   wire [7:0]  subindex   = index[7:0];
   wire [2:0]  width      = link.channel_width_setting;
   wire        wide       = (width >= PCC_WORDS_32BIT);
   wire        narrow_ok  = (width >= PCC_WORDS_16BIT);
   // fixed-length channel: last value word is word 3 or 4, always
   // below the limit for up to 15 process words
   wire [7:0]  last_word  = wide ? 8'h04 : 8'h03;
   wire        len_ok     = (last_word <
                            (8'(PCC_LINK_LIMIT) - {4'h0,
                             process_word_count}));
   wire [16:0] param_id;
   wire        id_ok;

   pcc_page_decode u_page (
      .index_word   (index),
      .param_number (param_number),
      .param_id     (param_id),
      .id_ok        (id_ok)
   );

   // store slot from low ID bits; the store stands in for real params
   wire [1:0] slot = param_id[1:0];
   wire       is_array_slot = (slot == 2'h3);

   // designation ID of the addressed parameter
   wire pcc_word_t desig = {1'b0,                 // 15 reserved
                            is_array_slot,        // array
                            1'b0,                 // 13 reset only
                            (store[slot] != '0),  // differs
                            1'b0,                 // 11 reserved
                            1'b0,                 // no text
                            1'b0,                 // 9 write prot
                            1'b0,                 // 8 scaling
                            8'h06};               // data type

   // -----------------------------------------------------------------
   // request evaluation
   // -----------------------------------------------------------------
   // failures first, then the accepted request kinds
   wire       bad_sub   = (subindex == PCC_SUB_ALL);
   wire       bad_chan  = !narrow_ok || !len_ok;
   wire       bad_type  = (req_code == PCC_RQ_WRITE_D) && !wide;
   wire       known     = (req_code == PCC_RQ_READ)    ||
                          (req_code == PCC_RQ_WRITE_W) ||
                          (req_code == PCC_RQ_WRITE_D) ||
                          (req_code == PCC_RQ_DESC);
   wire       do_write  = (state == PCC_ST_EXEC) && id_ok &&
                          !bad_sub && !bad_chan && !bad_type &&
                          ((req_code == PCC_RQ_WRITE_W) ||
                           (req_code == PCC_RQ_WRITE_D));
   wire pcc_word_t wr_data = (req_code == PCC_RQ_WRITE_D) ? value2
                          : (wide ? value2 : value1);

   pcc_word_t desc_val;
   always_comb begin
      // description element selected by subindex
      if (subindex == PCC_EL_DESIG) begin
         desc_val = desig;
      end else if (subindex == PCC_EL_COUNT) begin
         desc_val = is_array_slot ? 16'h0004 : 16'h0000;
      end else if (subindex == PCC_EL_LOWER) begin
         desc_val = 16'h0000;
      end else if (subindex == PCC_EL_UPPER) begin
         desc_val = 16'hFFFF;
      end else if (subindex == PCC_EL_DEFAULT) begin
         desc_val = 16'h0000;
      end else begin
         desc_val = 16'h0000;
      end
   end
   wire desc_ok = (subindex == PCC_EL_DESIG) ||
                  (subindex == PCC_EL_COUNT) ||
                  (subindex == PCC_EL_LOWER) ||
                  (subindex == PCC_EL_UPPER) ||
                  (subindex == PCC_EL_DEFAULT);

   pcc_word_t next_rsp [PCC_MAX_WORDS];
   pcc_word_t answer;
   logic [3:0] code;
   logic [15:0] err;
   logic        fail;
   always_comb begin
      // build response words
      fail   = 1'b0;
      err    = PCC_ERR_NOSUPP;
      answer = store[slot];
      code   = wide ? PCC_RS_DWORD : PCC_RS_WORD;
      if (bad_chan) begin
         fail = 1'b1;
         err  = PCC_ERR_SMALL;
      end else if (!id_ok) begin
         fail = 1'b1;
         err  = PCC_ERR_BAD_ID;
      end else if (bad_sub || !known) begin
         fail = 1'b1;
         err  = PCC_ERR_NOSUPP;
      end else if (bad_type) begin
         fail = 1'b1;
         err  = PCC_ERR_TYPE;
      end else if (req_code == PCC_RQ_DESC) begin
         fail   = !desc_ok;
         answer = desc_val;
         code   = PCC_RS_DESC;
      end
      if (fail) begin
         code   = PCC_RS_NOT_EXEC;
         answer = err;
      end
      next_rsp[PCC_IDX_IDENT] = {code, ident[11:0]};
      next_rsp[PCC_IDX_INDEX] = index;
      // in a wide channel a 16-bit answer sits in word 4, word 3 zero
      next_rsp[PCC_IDX_VALUE1] = wide ? 16'h0000 : answer;
      next_rsp[PCC_IDX_VALUE2] = wide ? answer : 16'h0000;
   end

   // -----------------------------------------------------------------
   // sequencing
   // -----------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         PCC_ST_IDLE: if (link.req_valid) next_state = PCC_ST_EXEC;
         PCC_ST_EXEC: next_state = PCC_ST_HOLD;
         PCC_ST_HOLD: if (!link.req_valid) next_state = PCC_ST_IDLE;
         default:     next_state = PCC_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= PCC_ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // response words latched once per request and held until it drops
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rsp_v         <= 1'b0;
         last_param_id <= '0;
         for (int i = 0; i < PCC_MAX_WORDS; i++) rsp[i] <= '0;
      end else if (state == PCC_ST_EXEC) begin
         rsp_v         <= 1'b1;
         last_param_id <= param_id;
         for (int i = 0; i < PCC_MAX_WORDS; i++) rsp[i] <= next_rsp[i];
      end else if (state == PCC_ST_IDLE) begin
         rsp_v <= 1'b0;
      end
   end

   // parameter store, one word per slot
   generate
      for (genvar g = 0; g < PCC_STORE_N; g++) begin : g_store
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               store[g] <= '0;
            end else if (do_write && (slot == 2'(g))) begin
               store[g] <= wr_data;
            end
         end
      end
   endgenerate

   assign link.rsp_valid = rsp_v;
   assign link.rsp_word  = rsp;
   assign busy           = (state != PCC_ST_IDLE);
endmodule

// >>> core/pcc_pkg.sv
/*
 Package for the parameter channel codec: word layout, page index
 scrambling, description elements, designation ID bits, response codes.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package pcc_pkg;
   // -----------------------------------------------------------------
   // channel layout
   // -----------------------------------------------------------------
   localparam int          PCC_WORD_W      = 16;
   localparam int          PCC_MAX_WORDS   = 4;
   localparam logic [2:0]  PCC_WORDS_16BIT = 3'h3;
   localparam logic [2:0]  PCC_WORDS_32BIT = 3'h4;
   localparam logic [1:0]  PCC_IDX_IDENT   = 2'h0;
   localparam logic [1:0]  PCC_IDX_INDEX   = 2'h1;
   localparam logic [1:0]  PCC_IDX_VALUE1  = 2'h2;
   localparam logic [1:0]  PCC_IDX_VALUE2  = 2'h3;
   localparam int          PCC_LINK_LIMIT  = 124;
   // -----------------------------------------------------------------
   // identifier word fields
   // -----------------------------------------------------------------
   localparam int          PCC_RESP_LSB    = 12;
   localparam int          PCC_PNUM_MSB    = 10;
   localparam logic [10:0] PCC_PNUM_MAX    = 11'h7CF;
   // -----------------------------------------------------------------
   // index word fields and page bit positions
   // -----------------------------------------------------------------
   localparam int          PCC_PG_A_BIT    = 15;
   localparam int          PCC_PG_D_BIT    = 14;
   localparam int          PCC_PG_C_BIT    = 13;
   localparam int          PCC_PG_B_BIT    = 12;
   localparam int          PCC_PG_F_BIT    = 11;
   localparam int          PCC_PG_E_BIT    = 10;
   localparam logic [16:0] PCC_PG_A_ADD    = 17'h007D0;
   localparam logic [16:0] PCC_PG_B_ADD    = 17'h00FA0;
   localparam logic [16:0] PCC_PG_C_ADD    = 17'h01F40;
   localparam logic [16:0] PCC_PG_D_ADD    = 17'h03E80;
   localparam logic [16:0] PCC_PG_E_ADD    = 17'h07D00;
   localparam logic [16:0] PCC_PG_F_ADD    = 17'h0FA00;
   localparam logic [16:0] PCC_PID_MAX     = 17'h0FFFF;
   localparam logic [7:0]  PCC_SUB_ALL     = 8'hFF;
   // -----------------------------------------------------------------
   // description elements
   // -----------------------------------------------------------------
   localparam logic [7:0]  PCC_EL_DESIG    = 8'h01;
   localparam logic [7:0]  PCC_EL_COUNT    = 8'h02;
   localparam logic [7:0]  PCC_EL_LOWER    = 8'h07;
   localparam logic [7:0]  PCC_EL_UPPER    = 8'h08;
   localparam logic [7:0]  PCC_EL_DEFAULT  = 8'h09;
   // -----------------------------------------------------------------
   // designation ID bits
   // -----------------------------------------------------------------
   localparam int          PCC_DS_TYPE_MSB = 7;
   localparam int          PCC_DS_SCALE    = 8;
   localparam int          PCC_DS_WPROT    = 9;
   localparam int          PCC_DS_TEXT     = 10;
   localparam int          PCC_DS_DIFFERS  = 12;
   localparam int          PCC_DS_RESETONLY= 13;
   localparam int          PCC_DS_ARRAY    = 14;
   localparam logic [15:0] PCC_DS_RSVD_MASK= 16'h8800;
   // -----------------------------------------------------------------
   // request / response codes
   // -----------------------------------------------------------------
   localparam logic [3:0]  PCC_RQ_NONE     = 4'h0;
   localparam logic [3:0]  PCC_RQ_READ     = 4'h1;
   localparam logic [3:0]  PCC_RQ_WRITE_W  = 4'h2;
   localparam logic [3:0]  PCC_RQ_WRITE_D  = 4'h3;
   localparam logic [3:0]  PCC_RQ_DESC     = 4'h4;
   localparam logic [3:0]  PCC_RS_NONE     = 4'h0;
   localparam logic [3:0]  PCC_RS_WORD     = 4'h1;
   localparam logic [3:0]  PCC_RS_DWORD    = 4'h2;
   localparam logic [3:0]  PCC_RS_DESC     = 4'h3;
   localparam logic [3:0]  PCC_RS_NOT_EXEC = 4'h7;
   localparam logic [15:0] PCC_ERR_BAD_ID  = 16'h0000;
   localparam logic [15:0] PCC_ERR_TYPE    = 16'h0005;
   localparam logic [15:0] PCC_ERR_SMALL   = 16'h0066;
   localparam logic [15:0] PCC_ERR_NOSUPP  = 16'h006A;

   typedef logic [PCC_WORD_W-1:0] pcc_word_t;
endpackage

// >>> core/pcc_link_if.sv
/*
 Interface joining the master end and the device end of the channel.
 Assumes both ends share clk; words move in parallel with a strobe.
*/
`timescale 1ns/100ps
interface pcc_link_if;
   import pcc_pkg::*;
   logic      req_valid;
   pcc_word_t req_word [PCC_MAX_WORDS];
   logic      rsp_valid;
   pcc_word_t rsp_word [PCC_MAX_WORDS];
   logic [2:0] channel_width_setting;

   modport master (output req_valid, output req_word,
                   output channel_width_setting,
                   input rsp_valid, input rsp_word);
   modport device (input req_valid, input req_word,
                   input channel_width_setting,
                   output rsp_valid, output rsp_word);
endinterface

// >>> core/pcc_page_decode.sv
/*
 Combines the scrambled page index and the in-page number into a full
 parameter ID. Purely combinational; assumes a 16-bit index word.
*/
`timescale 1ns/100ps
module pcc_page_decode
   import pcc_pkg::*;
(
   input  wire logic [15:0] index_word,
   input  wire logic [10:0] param_number,
   output logic      [16:0] param_id,
   output logic             id_ok
);
   // -----------------------------------------------------------------
   // page weights
   // -----------------------------------------------------------------
   // each page bit adds its own multiple of 2000; bits 9:8 are ignored
   wire [16:0] add_a = index_word[PCC_PG_A_BIT] ? PCC_PG_A_ADD : '0;
   wire [16:0] add_b = index_word[PCC_PG_B_BIT] ? PCC_PG_B_ADD : '0;
   wire [16:0] add_c = index_word[PCC_PG_C_BIT] ? PCC_PG_C_ADD : '0;
   wire [16:0] add_d = index_word[PCC_PG_D_BIT] ? PCC_PG_D_ADD : '0;
   wire [16:0] add_e = index_word[PCC_PG_E_BIT] ? PCC_PG_E_ADD : '0;
   wire [16:0] add_f = index_word[PCC_PG_F_BIT] ? PCC_PG_F_ADD : '0;
   wire [16:0] page  = add_a + add_b + add_c + add_d + add_e + add_f;

   // sum of page base and in-page number
   assign param_id = page + {6'h00, param_number};
   // in-page number above 1999 or ID past 65535 is refused
   assign id_ok    = (param_number <= PCC_PNUM_MAX) &&
                     (param_id <= PCC_PID_MAX);
endmodule

// >>> core/pcc_master.sv
/*
 Master end of the parameter channel: packs a user request into the
 channel words and returns the response. Assumes one request at a time.
*/
`timescale 1ns/100ps
module pcc_master
   import pcc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   pcc_link_if.master       link,
   input  wire logic        start,
   input  wire logic [3:0]  req_code,
   input  wire logic [5:0]  page_bits,
   input  wire logic [10:0] param_number,
   input  wire logic [7:0]  subindex,
   input  wire logic [15:0] first_value_word,
   input  wire logic [15:0] second_value_word,
   input  wire logic        wide_channel,
   output logic             done,
   output logic      [3:0]  rsp_code,
   output logic      [15:0] param_value_word,
   output logic             ready
);
   logic      pend;
   pcc_word_t req [PCC_MAX_WORDS];

   // -----------------------------------------------------------------
   // request packing
   // -----------------------------------------------------------------
   // page_bits is given in a,d,c,b,f,e order, as on the wire
   wire pcc_word_t idx = {page_bits, 2'b00, subindex};
   wire pcc_word_t idn = {req_code, 1'b0, param_number};

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pend <= 1'b0;
         for (int i = 0; i < PCC_MAX_WORDS; i++) req[i] <= '0;
      end else if (start && !pend) begin
         pend <= 1'b1;
         req[PCC_IDX_IDENT]  <= idn;
         req[PCC_IDX_INDEX]  <= idx;
         req[PCC_IDX_VALUE1] <= first_value_word;
         req[PCC_IDX_VALUE2] <= wide_channel ? second_value_word
                                             : 16'h0000;
      end else if (pend && link.rsp_valid) begin
         pend <= 1'b0;
      end
   end

   // response capture; value taken from word 4 in a wide channel
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         done             <= 1'b0;
         rsp_code         <= '0;
         param_value_word <= '0;
      end else begin
         done <= pend && link.rsp_valid;
         if (pend && link.rsp_valid) begin
            rsp_code         <= link.rsp_word[PCC_IDX_IDENT][15:12];
            param_value_word <= wide_channel
                                ? link.rsp_word[PCC_IDX_VALUE2]
                                : link.rsp_word[PCC_IDX_VALUE1];
         end
      end
   end

   assign link.req_valid = pend;
   assign link.req_word  = req;
   assign link.channel_width_setting = wide_channel ? PCC_WORDS_32BIT
                                                    : PCC_WORDS_16BIT;
   assign ready = !pend && !link.rsp_valid;
endmodule

// >>> tb/pcc_link_props.sv
/*
 Checker for the channel between the master end and the device end.
 Assumes it sits beside the link interface on the bench clock.
*/
`timescale 1ns/100ps
module pcc_link_props
   import pcc_pkg::*;
(
   input wire logic       clk,
   input wire logic       reset_n,
   input wire logic       req_valid,
   input wire pcc_word_t  req_word [PCC_MAX_WORDS],
   input wire logic       rsp_valid,
   input wire pcc_word_t  rsp_word [PCC_MAX_WORDS],
   input wire logic [2:0] channel_width_setting
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // ------------------------------------------------------------
   // decoded views of the answer phase
   // ------------------------------------------------------------
   // request words are only trusted while req_valid is still high
   wire        ans   = req_valid && rsp_valid;
   wire [3:0]  rcode = rsp_word[0][15:12];
   wire        wide  = channel_width_setting == PCC_WORDS_32BIT;
   wire [15:0] rval  = wide ? rsp_word[3] : rsp_word[2];
   wire [7:0]  sub   = req_word[1][7:0];
   wire        el_ok = sub == PCC_EL_DESIG || sub == PCC_EL_COUNT ||
                       sub == PCC_EL_LOWER || sub == PCC_EL_UPPER ||
                       sub == PCC_EL_DEFAULT;
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   rsp_time_a: assert property ($rose(req_valid) |-> ##[1:4] rsp_valid)
      else $error("request not answered in time");
   req_hold_a: assert property (req_valid && !rsp_valid |=> req_valid &&
      $stable(req_word[0]) && $stable(req_word[1]))
      else $error("request dropped or changed early");
   rsp_hold_a: assert property (ans |=> rsp_valid)
      else $error("answer withdrawn early");
   rsp_drop_a: assert property (!req_valid |-> ##[0:3] !rsp_valid)
      else $error("answer stays after request end");
   idx_rsvd_a: assert property (req_valid |-> req_word[1][9:8] == 2'h0)
      else $error("reserved index bits set");
   echo_ok_a: assert property (ans |-> rsp_word[1] == req_word[1] &&
      rsp_word[0][11:0] == req_word[0][11:0])
      else $error("index or number not echoed");
   low_zero_a: assert property (ans && wide &&
      (rcode == PCC_RS_WORD || rcode == PCC_RS_DESC) |-> rsp_word[2] == 16'h0)
      else $error("first value word not zero");
   narrow_a: assert property (ans && !wide |-> rcode != PCC_RS_DWORD)
      else $error("double word on narrow channel");
   pnum_range_a: assert property (ans && req_word[0][10:0] >
      PCC_PNUM_MAX |-> rcode == PCC_RS_NOT_EXEC && rval == PCC_ERR_BAD_ID)
      else $error("bad in-page number accepted");
   sub_all_a: assert property (ans && sub == PCC_SUB_ALL
      |-> rcode == PCC_RS_NOT_EXEC)
      else $error("whole-array subindex accepted");
   elem_rsvd_a: assert property (ans && req_word[0][15:12] == PCC_RQ_DESC
      && !el_ok |-> rcode == PCC_RS_NOT_EXEC)
      else $error("reserved element accepted");
endmodule

// >>> tb/parameter_channel_codec_test.sv
/*
 Bench joining master and device ends through the link interface.
 Assumes the hand-over timing: one request at a time, ready gates start.
*/
`timescale 1ns/100ps
module parameter_channel_codec_test;
   import pcc_pkg::*;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        start = 1'b0;
   logic [3:0]  req_code = 4'h0;
   logic [5:0]  page_bits = 6'h0;
   logic [10:0] param_number = 11'h0;
   logic [7:0]  subindex = 8'h0;
   logic [15:0] first_value_word = 16'h0;
   logic [15:0] second_value_word = 16'h0;
   logic        wide_channel = 1'b0;
   logic [3:0]  process_word_count = 4'h4;
   logic        done, ready, busy;
   logic [3:0]  rsp_code;
   logic [15:0] param_value_word;
   logic [16:0] last_param_id;
   int          fail_count = 0;
   int          cmp_count = 0;
   // page weights, a d c b f e from page_bits[5] downwards
   logic [16:0] pg_add [6] = '{17'h007D0, 17'h03E80, 17'h01F40,
                               17'h00FA0, 17'h0FA00, 17'h07D00};
   always #20 clk = ~clk;
   // ------------------------------------------------------------
   // the two ends and the checker
   // ------------------------------------------------------------
   pcc_link_if pcc_link_if_i ();
   pcc_master pcc_master_i (.clk(clk), .reset_n(reset_n),
      .link(pcc_link_if_i), .start(start), .req_code(req_code),
      .page_bits(page_bits), .param_number(param_number),
      .subindex(subindex), .first_value_word(first_value_word),
      .second_value_word(second_value_word),
      .wide_channel(wide_channel), .done(done), .rsp_code(rsp_code),
      .param_value_word(param_value_word), .ready(ready));
   pcc_device pcc_device_i (.clk(clk), .reset_n(reset_n),
      .link(pcc_link_if_i), .process_word_count(process_word_count),
      .last_param_id(last_param_id), .busy(busy));
   pcc_link_props pcc_link_props_i (.clk(clk), .reset_n(reset_n),
      .req_valid(pcc_link_if_i.req_valid),
      .req_word(pcc_link_if_i.req_word),
      .rsp_valid(pcc_link_if_i.rsp_valid),
      .rsp_word(pcc_link_if_i.rsp_word),
      .channel_width_setting(pcc_link_if_i.channel_width_setting));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [16:0] exp,
                        input logic [16:0] got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // expected ID is summed here, not taken from the decoder
   function automatic logic [16:0] pid(input logic [5:0] pg,
                                       input logic [10:0] pn);
      pid = {6'h0, pn};
      for (int i = 0; i < 6; i++)
         if (pg[5-i]) pid = pid + pg_add[i];
   endfunction
   // one request; waits are bounded so a hang shows as a mismatch
   task automatic op(input logic [3:0] rq, input logic [5:0] pg,
                     input logic [10:0] pn, input logic [7:0] sb,
                     input logic [15:0] val, input logic [3:0] ecode,
                     input logic [15:0] evalue);
      int n;
      n = 0;
      while (ready !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1;
         n++;
      end
      // a wait that ran out shows here rather than passing silently
      check("ready", 17'h1, {16'h0, ready});
      check("busy", 17'h0, {16'h0, busy});
      req_code = rq;
      page_bits = pg;
      param_number = pn;
      subindex = sb;
      first_value_word = val;
      second_value_word = val;
      start = 1'b1;
      @(posedge clk);
      #1;
      start = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1;
         n++;
      end
      // done stands for one cycle; stale answers must not pass
      check("done", 17'h1, {16'h0, done});
      check("busy", 17'h1, {16'h0, busy});
      check("code", {13'h0, ecode}, {13'h0, rsp_code});
      check("value", {1'b0, evalue}, {1'b0, param_value_word});
      if (ecode !== PCC_RS_NOT_EXEC)
         check("id", pid(pg, pn), last_param_id);
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ------------------------------------------------------------
   // watchdog and main sequence
   // ------------------------------------------------------------
   // the sequence needs about 170 cycles; allow 3000, about eighteen times that
   initial begin
      #120000;
      fail_count++;
      end_sim();
   end
   initial begin
      repeat (12) @(posedge clk);
      #1;
      reset_n = 1'b1;
      for (int i = 0; i < 6; i++)
         op(PCC_RQ_READ, 6'h20 >> i, 11'h005, 8'h0,
            16'h0, PCC_RS_WORD, 16'h0);
      op(PCC_RQ_READ, 6'h24, 11'h7CF, 8'h0, 16'h0,
         PCC_RS_WORD, 16'h0);
      // a write answers with the contents held before the write
      op(PCC_RQ_WRITE_W, 6'h0, 11'h001, 8'h0, 16'hA5C3,
         PCC_RS_WORD, 16'h0);
      op(PCC_RQ_READ, 6'h0, 11'h001, 8'h0, 16'h0,
         PCC_RS_WORD, 16'hA5C3);
      op(PCC_RQ_WRITE_D, 6'h0, 11'h002, 8'h0, 16'h1234,
         PCC_RS_NOT_EXEC, PCC_ERR_TYPE);
      op(PCC_RQ_READ, 6'h0, 11'h7D0, 8'h0, 16'h0,
         PCC_RS_NOT_EXEC, PCC_ERR_BAD_ID);
      op(PCC_RQ_READ, 6'h02, 11'h5FF, 8'h0, 16'h0,
         PCC_RS_WORD, 16'h0);
      op(PCC_RQ_READ, 6'h02, 11'h600, 8'h0, 16'h0,
         PCC_RS_NOT_EXEC, PCC_ERR_BAD_ID);
      op(PCC_RQ_READ, 6'h0, 11'h001, 8'hFF, 16'h0,
         PCC_RS_NOT_EXEC, PCC_ERR_NOSUPP);
      // an empty request code is an order the device cannot execute
      op(PCC_RQ_NONE, 6'h0, 11'h001, 8'h0, 16'h0,
         PCC_RS_NOT_EXEC, PCC_ERR_NOSUPP);
      op(PCC_RQ_DESC, 6'h0, 11'h001, PCC_EL_DESIG, 16'h0,
         PCC_RS_DESC, 16'h1006);
      op(PCC_RQ_DESC, 6'h0, 11'h003, PCC_EL_DESIG, 16'h0,
         PCC_RS_DESC, 16'h4006);
      op(PCC_RQ_DESC, 6'h0, 11'h003, PCC_EL_COUNT, 16'h0,
         PCC_RS_DESC, 16'h0004);
      op(PCC_RQ_DESC, 6'h0, 11'h001, PCC_EL_LOWER, 16'h0,
         PCC_RS_DESC, 16'h0000);
      op(PCC_RQ_DESC, 6'h0, 11'h001, PCC_EL_UPPER, 16'h0,
         PCC_RS_DESC, 16'hFFFF);
      op(PCC_RQ_DESC, 6'h0, 11'h001, PCC_EL_DEFAULT, 16'h0,
         PCC_RS_DESC, 16'h0);
      op(PCC_RQ_DESC, 6'h0, 11'h001, 8'h03, 16'h0,
         PCC_RS_NOT_EXEC, PCC_ERR_NOSUPP);
      // switch width only while idle; the master holds it as a level
      wide_channel = 1'b1;
      process_word_count = 4'hF;
      op(PCC_RQ_WRITE_D, 6'h0, 11'h002, 8'h0, 16'h5A3C,
         PCC_RS_DWORD, 16'h0);
      // the wide channel always answers a value as a double word
      op(PCC_RQ_READ, 6'h0, 11'h002, 8'h0, 16'h0,
         PCC_RS_DWORD, 16'h5A3C);
      op(PCC_RQ_DESC, 6'h0, 11'h002, PCC_EL_DESIG, 16'h0,
         PCC_RS_DESC, 16'h1006);
      op(PCC_RQ_READ, 6'h10, 11'h7D0, 8'h0, 16'h0,
         PCC_RS_NOT_EXEC, PCC_ERR_BAD_ID);
      end_sim();
   end
endmodule
